// file: smd_pkg.sv
// Shared constants for the sector-map detection descriptor table and its reader
package smd_pkg;

   // Descriptor field values
   localparam logic [7:0]  SMD_INSTR_READ_ANY  = 8'h65;
   localparam logic [1:0]  SMD_ADDR_LEN_VAR    = 2'h3;
   localparam logic [3:0]  SMD_LATENCY_VAR     = 4'hf;
   localparam logic [1:0]  SMD_RSVD_HI         = 2'h3;
   localparam logic [5:0]  SMD_RSVD_LO         = 6'h3f;
   localparam logic        SMD_CMD_DESC_FLAG   = 1'h0;
   localparam logic        SMD_END_DESC_FLAG   = 1'h0;
   localparam logic [7:0]  SMD_MASK_LAYOUT     = 8'h08;
   localparam logic [7:0]  SMD_MASK_PARAM_LOC  = 8'h04;
   localparam logic [31:0] SMD_ADDR_NV_CFG3    = 32'h0000_0004;
   localparam logic [31:0] SMD_ADDR_NV_CFG1    = 32'h0000_0002;

   // Field positions inside the first dword of a descriptor
   localparam int SMD_MASK_LSB    = 24;
   localparam int SMD_ALEN_LSB    = 22;
   localparam int SMD_LAT_LSB     = 16;
   localparam int SMD_INSTR_LSB   = 8;
   localparam int SMD_CMD_BIT     = 1;
   localparam int SMD_END_BIT     = 0;

   // Table placement in the two query spaces
   localparam logic [7:0]  SMD_SFDP_BASE       = 8'h48;
   localparam logic [7:0]  SMD_ALT_SKEW        = 8'h02;
   localparam logic [7:0]  SMD_ALT_BASE        = SMD_SFDP_BASE + SMD_ALT_SKEW;
   localparam logic [7:0]  SMD_TBL_BYTES       = 8'h10;
   localparam logic [7:0]  SMD_FILL_BYTE       = 8'hff;
   localparam logic [4:0]  SMD_TBL_LEN_M1      = 5'h0f;

   // Controller register map, byte addresses
   localparam logic [7:0]  SMD_REG_CTRL        = 8'h00;
   localparam logic [7:0]  SMD_REG_STATUS      = 8'h04;
   localparam logic [7:0]  SMD_REG_PROBE0      = 8'h08;
   localparam logic [7:0]  SMD_REG_PROBE1      = 8'h0c;
   localparam logic [7:0]  SMD_REG_DESC        = 8'h10;
   localparam int SMD_CTRL_START  = 0;
   localparam int SMD_CTRL_ALT    = 1;
   localparam int SMD_ST_BUSY     = 0;
   localparam int SMD_ST_DONE     = 1;
   localparam int SMD_ST_OK       = 2;

   typedef enum logic {
      SMD_SPACE_SFDP = 1'b0,
      SMD_SPACE_ALT  = 1'b1
   } smd_space_t;

   typedef enum logic [1:0] {
      SMD_D_IDLE = 2'b01,
      SMD_D_SEND = 2'b10
   } smd_dstate_t;

   typedef enum logic [3:0] {
      SMD_H_IDLE  = 4'b0001,
      SMD_H_REQ   = 4'b0010,
      SMD_H_RECV  = 4'b0100,
      SMD_H_CHECK = 4'b1000
   } smd_hstate_t;

endpackage : smd_pkg

// file: smd_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// Byte link between the table reader and the descriptor table
interface smd_link_if (
   input wire logic mclk
);
   import smd_pkg::*;

   logic        req_valid;   // One-cycle read request
   smd_space_t  req_space;   // Query space of req_offset
   logic [7:0]  req_offset;  // First byte offset
   logic [4:0]  req_len_m1;  // Byte count minus one
   logic        rsp_valid;   // One byte per cycle
   logic [7:0]  rsp_data;
   logic        rsp_last;
   logic        dev_busy;    // Requests are ignored while high

   modport dev (
      input  req_valid, req_space, req_offset, req_len_m1,
      output rsp_valid, rsp_data, rsp_last, dev_busy
   );

   modport host (
      output req_valid, req_space, req_offset, req_len_m1,
      input  rsp_valid, rsp_data, rsp_last, dev_busy
   );

endinterface : smd_link_if
`default_nettype wire

// file: smd_rom_dev.sv
// Overview of operation
// [RULE1] First descriptor dword reads FC 65 FF 08
// [RULE2] Mask 08h selects layout bit three
// [RULE3] Mask 04h selects parameter sector location bit
// [RULE4] Both descriptors name read-any-register instruction 65h
// [RULE5] Address length and latency coded as variable
// [RULE6] First probe address is register three, 04h
// [RULE7] Second descriptor FC 65 FF 04, address 02h
// [RULE8] Command and end flags both read zero
// [RULE9] Reserved fields read back as all ones
// [RULE10] Dwords leave least significant byte first
// [RULE11] Alternate space sits two bytes higher
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module smd_rom_dev
   import smd_pkg::*;
#(
   parameter logic [7:0] TBL_BYTES = SMD_TBL_BYTES
) (
   input  wire logic  mclk,
   input  wire logic  rstn,
   input  wire logic  ce,
   smd_link_if.dev    lnk,
   output var  logic  dev_active,
   output var  logic  dev_miss
);

   // Whole state of the table end
   typedef struct packed {
      smd_dstate_t st;
      logic [7:0]  idx;
      logic [4:0]  left;
      logic [7:0]  data;
      logic        valid;
      logic        last;
      logic        busy;
      logic        miss;
   } smd_dev_state_t;

   localparam smd_dev_state_t SMD_DEV_RST = '{
      st:    SMD_D_IDLE,
      idx:   8'h00,
      left:  5'h00,
      data:  8'h00,
      valid: 1'b0,
      last:  1'b0,
      busy:  1'b0,
      miss:  1'b0
   };

   smd_dev_state_t state_r;
   smd_dev_state_t state_nxt;

   // Builds the first dword of a detection descriptor from its mask
   function automatic logic [31:0] smd_desc_head(input logic [7:0] mask);
      logic [31:0] d;
      d = 32'h0000_0000;
      d[SMD_MASK_LSB +: 8]  = mask;                 // see [RULE2] see [RULE3]
      d[SMD_ALEN_LSB +: 2]  = SMD_ADDR_LEN_VAR;     // see [RULE5]
      d[SMD_ALEN_LSB - 2 +: 2] = SMD_RSVD_HI;       // see [RULE9]
      d[SMD_LAT_LSB +: 4]   = SMD_LATENCY_VAR;      // see [RULE5]
      d[SMD_INSTR_LSB +: 8] = SMD_INSTR_READ_ANY;   // see [RULE4]
      d[SMD_CMD_BIT + 1 +: 6] = SMD_RSVD_LO;        // see [RULE9]
      d[SMD_CMD_BIT]        = SMD_CMD_DESC_FLAG;    // see [RULE8]
      d[SMD_END_BIT]        = SMD_END_DESC_FLAG;    // see [RULE8]
      return d;
   endfunction : smd_desc_head

   // Dword number two bits wide: head and address of each descriptor
   function automatic logic [31:0] smd_dword(input logic [1:0] n);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (n)
         2'h0: d = smd_desc_head(SMD_MASK_LAYOUT);     // see [RULE1]
         2'h1: d = SMD_ADDR_NV_CFG3;                   // see [RULE6]
         2'h2: d = smd_desc_head(SMD_MASK_PARAM_LOC);  // see [RULE7]
         2'h3: d = SMD_ADDR_NV_CFG1;                   // see [RULE7]
      endcase
      return d;
   endfunction : smd_dword

   // Byte at a table-relative index, low byte of each dword first
   function automatic logic [7:0] smd_byte(input logic [7:0] rel);
      logic [31:0] d;
      d = smd_dword(rel[3:2]);
      return d[{rel[1:0], 3'h0} +: 8];                 // see [RULE10]
   endfunction : smd_byte

   // Converts a request offset to a table-relative index
   function automatic logic [7:0] smd_rel(input smd_space_t sp, input logic [7:0] off);
      logic [7:0] r;
      if (sp == SMD_SPACE_ALT) begin
         r = off - SMD_ALT_BASE;                       // see [RULE11]
      end else begin
         r = off - SMD_SFDP_BASE;
      end
      return r;
   endfunction : smd_rel

   logic in_table;
   assign in_table = (state_r.idx < TBL_BYTES);

   // One byte per cycle; outside the table the bus floats high as a blank
   // part would, so a host that overruns sees erased-looking data
   always_comb begin
      state_nxt       = state_r;
      state_nxt.valid = 1'b0;
      state_nxt.last  = 1'b0;
      state_nxt.miss  = 1'b0;
      unique case (state_r.st)
         SMD_D_IDLE: begin
            if (lnk.req_valid) begin
               state_nxt.st   = SMD_D_SEND;
               state_nxt.idx  = smd_rel(lnk.req_space, lnk.req_offset);
               state_nxt.left = lnk.req_len_m1;
               state_nxt.busy = 1'b1;
            end
         end
         SMD_D_SEND: begin
            state_nxt.valid = 1'b1;
            state_nxt.data  = in_table ? smd_byte(state_r.idx) : SMD_FILL_BYTE;
            state_nxt.miss  = ~in_table;
            state_nxt.idx   = state_r.idx + 8'h01;
            if (state_r.left == 5'h00) begin
               state_nxt.last = 1'b1;
               state_nxt.st   = SMD_D_IDLE;
               state_nxt.busy = 1'b0;
            end else begin
               state_nxt.left = state_r.left - 5'h01;
            end
         end
      endcase
   end

   // Clock enable low freezes every bit of state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= SMD_DEV_RST;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // All outputs come straight from the state register
   assign lnk.rsp_valid = state_r.valid;
   assign lnk.rsp_data  = state_r.data;
   assign lnk.rsp_last  = state_r.last;
   assign lnk.dev_busy  = state_r.busy;
   assign dev_active    = state_r.busy;
   assign dev_miss      = state_r.miss;

endmodule : smd_rom_dev
`default_nettype wire

// file: smd_host_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module smd_host_ctl
   import smd_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        ce,
   smd_link_if.host         lnk,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [31:0] reg_rdata
);

   // Whole state of the reader
   typedef struct packed {
      smd_hstate_t st;
      smd_space_t  space;
      logic [3:0]  cnt;
      logic [3:0][31:0] dw;
      logic        done;
      logic        ok;
      logic        req_valid;
      logic [7:0]  req_off;
      logic [31:0] rdata;
   } smd_host_state_t;

   localparam smd_host_state_t SMD_HOST_RST = '{
      st:        SMD_H_IDLE,
      space:     SMD_SPACE_SFDP,
      cnt:       4'h0,
      dw:        '0,
      done:      1'b0,
      ok:        1'b0,
      req_valid: 1'b0,
      req_off:   8'h00,
      rdata:     32'h0000_0000
   };

   smd_host_state_t state_r;
   smd_host_state_t state_nxt;

   // A descriptor head is usable only with the expected command coding
   function automatic logic smd_head_ok(input logic [31:0] d);
      return (d[SMD_INSTR_LSB +: 8] == SMD_INSTR_READ_ANY)     // see [RULE4]
          && (d[SMD_ALEN_LSB +: 2] == SMD_ADDR_LEN_VAR)       // see [RULE5]
          && (d[SMD_LAT_LSB +: 4] == SMD_LATENCY_VAR)         // see [RULE5]
          && (d[SMD_CMD_BIT] == SMD_CMD_DESC_FLAG)            // see [RULE8]
          && (d[SMD_END_BIT] == SMD_END_DESC_FLAG);           // see [RULE8]
   endfunction : smd_head_ok

   // Fetch sequence, register writes and reads
   always_comb begin
      state_nxt           = state_r;
      state_nxt.req_valid = 1'b0;
      state_nxt.rdata     = 32'h0000_0000;
      unique case (state_r.st)
         SMD_H_IDLE: begin
            if (reg_wr && reg_addr == SMD_REG_CTRL && reg_wdata[SMD_CTRL_START]) begin
               state_nxt.space = smd_space_t'(reg_wdata[SMD_CTRL_ALT]);
               state_nxt.st    = SMD_H_REQ;
               state_nxt.ok    = 1'b0;
               state_nxt.cnt   = 4'h0;
            end
         end
         SMD_H_REQ: begin
            if (!lnk.dev_busy) begin
               state_nxt.req_valid = 1'b1;
               state_nxt.req_off   = (state_r.space == SMD_SPACE_ALT) ? SMD_ALT_BASE
                                                                       : SMD_SFDP_BASE; // see [RULE11]
               state_nxt.st        = SMD_H_RECV;
            end
         end
         SMD_H_RECV: begin
            if (lnk.rsp_valid) begin
               // Low byte first within each dword
               state_nxt.dw[state_r.cnt[3:2]][{state_r.cnt[1:0], 3'h0} +: 8] = lnk.rsp_data; // see [RULE10]
               state_nxt.cnt = state_r.cnt + 4'h1;
               if (lnk.rsp_last) begin
                  state_nxt.st = SMD_H_CHECK;
               end
            end
         end
         SMD_H_CHECK: begin
            // Masks must pick the layout bit and the location bit
            state_nxt.ok = smd_head_ok(state_r.dw[0]) && smd_head_ok(state_r.dw[2])
                        && (state_r.dw[0][SMD_MASK_LSB +: 8] == SMD_MASK_LAYOUT)     // see [RULE2]
                        && (state_r.dw[2][SMD_MASK_LSB +: 8] == SMD_MASK_PARAM_LOC); // see [RULE3]
            state_nxt.done = 1'b1;
            state_nxt.st   = SMD_H_IDLE;
         end
      endcase
      // Writing one to done clears it; a completion in that cycle wins
      if (reg_wr && reg_addr == SMD_REG_STATUS && reg_wdata[SMD_ST_DONE]
          && state_r.st != SMD_H_CHECK) begin
         state_nxt.done = 1'b0;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            SMD_REG_STATUS: begin
               state_nxt.rdata[SMD_ST_BUSY] = (state_r.st != SMD_H_IDLE);
               state_nxt.rdata[SMD_ST_DONE] = state_r.done;
               state_nxt.rdata[SMD_ST_OK]   = state_r.ok;
            end
            SMD_REG_PROBE0: state_nxt.rdata = state_r.dw[1];
            SMD_REG_PROBE1: state_nxt.rdata = state_r.dw[3];
            SMD_REG_DESC:   state_nxt.rdata = {state_r.dw[0][SMD_MASK_LSB +: 8],
                                               state_r.dw[2][SMD_MASK_LSB +: 8],
                                               state_r.dw[0][SMD_INSTR_LSB +: 8],
                                               state_r.dw[2][SMD_INSTR_LSB +: 8]};
            default:        state_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // Clock enable low freezes every bit of state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= SMD_HOST_RST;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   assign lnk.req_valid  = state_r.req_valid;
   assign lnk.req_space  = state_r.space;
   assign lnk.req_offset = state_r.req_off;
   assign lnk.req_len_m1 = SMD_TBL_LEN_M1;   // Fixed sixteen-byte fetch
   assign reg_rdata      = state_r.rdata;

endmodule : smd_host_ctl
`default_nettype wire

// file: smd_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Protocol watcher on the byte link between the table reader and the table
module smd_link_properties
   import smd_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rstn,
   input wire logic       req_valid,
   input wire smd_space_t req_space,
   input wire logic [7:0] req_offset,
   input wire logic [4:0] req_len_m1,
   input wire logic       rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic       rsp_last,
   input wire logic       dev_busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // One byte of the table on the link
   sequence beat_s(logic [7:0] b);
      rsp_valid && (rsp_data == b);
   endsequence
   sequence first_desc_s;
      beat_s(8'hfc) ##1 beat_s(8'h65) ##1 beat_s(8'hff) ##1 beat_s(8'h08)
      ##1 beat_s(8'h04) ##1 beat_s(8'h00) ##1 beat_s(8'h00) ##1 beat_s(8'h00);
   endsequence
   sequence second_desc_s;
      beat_s(8'hfc) ##1 beat_s(8'h65) ##1 beat_s(8'hff) ##1 beat_s(8'h04)
      ##1 beat_s(8'h02) ##1 beat_s(8'h00) ##1 beat_s(8'h00) ##1 beat_s(8'h00);
   endsequence
   // Only an idle table takes a request; one made while busy is dropped
   sequence take_sfdp_s;
      req_valid && !dev_busy && (req_space == SMD_SPACE_SFDP) && (req_offset == 8'h48);
   endsequence
   sequence take_alt_s;
      req_valid && !dev_busy && (req_space == SMD_SPACE_ALT) && (req_offset == 8'h4a);
   endsequence

   chk_first_desc: assert property (take_sfdp_s |-> ##2 first_desc_s)
      else $error("first descriptor bytes wrong");
   chk_second_desc: assert property (take_sfdp_s |-> ##10 second_desc_s)
      else $error("second descriptor bytes wrong");
   chk_alt_copy: assert property (take_alt_s |-> ##2 first_desc_s ##1 second_desc_s)
      else $error("alternate space bytes wrong");
   chk_instr_codes: assert property (take_sfdp_s |-> ##3 (rsp_data == SMD_INSTR_READ_ANY)
      ##1 (rsp_data == {SMD_ADDR_LEN_VAR, SMD_RSVD_HI, SMD_LATENCY_VAR}) ##7 (rsp_data == SMD_INSTR_READ_ANY))
      else $error("instruction or variable codes wrong");
   chk_flag_bits: assert property (take_sfdp_s |-> ##2 (rsp_data == {SMD_RSVD_LO, 2'b00})
      ##8 (rsp_data == {SMD_RSVD_LO, SMD_CMD_DESC_FLAG, SMD_END_DESC_FLAG}))
      else $error("flag or reserved bits wrong");
   chk_last_beat: assert property (req_valid && !dev_busy |-> ##1 (!rsp_last)[*8] ##9 rsp_last)
      else $error("last byte not at sixteenth beat");
   chk_rsp_cause: assert property ($rose(rsp_valid) |-> $past(req_valid, 2))
      else $error("byte stream without request");
   chk_len_fixed: assert property (req_valid |-> req_len_m1 == SMD_TBL_LEN_M1)
      else $error("request length not whole table");
   chk_req_place: assert property (req_valid |-> (req_space == SMD_SPACE_SFDP) ?
      (req_offset == 8'h48) : (req_offset == 8'h4a))
      else $error("request offset wrong for space");
endmodule : smd_link_properties
`default_nettype wire

// file: sector_map_detect_descriptor_rom_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sector_map_detect_descriptor_rom_tb_top;
   import smd_pkg::*;
   logic        mclk, rstn, ce, reg_wr, reg_rd, dev_miss, dev_active;
   logic        rd_d = 1'b0;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, seed, r;
   int          fail_count = 0;
   int          n_tests = 0;
   logic [31:0] exp_q[$];
   logic [7:0]  byte_q[$];
   localparam logic [7:0] TBL [16] = '{8'hfc, 8'h65, 8'hff, 8'h08, 8'h04, 8'h00, 8'h00, 8'h00,
                                       8'hfc, 8'h65, 8'hff, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00};

   smd_link_if lnk (.mclk(mclk));
   smd_rom_dev smd_rom_dev_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .lnk(lnk.dev),
      .dev_active(dev_active), .dev_miss(dev_miss));
   smd_host_ctl smd_host_ctl_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .lnk(lnk.host),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   smd_link_properties smd_link_properties_inst (.mclk(mclk), .rstn(rstn), .req_valid(lnk.req_valid),
      .req_space(lnk.req_space), .req_offset(lnk.req_offset), .req_len_m1(lnk.req_len_m1),
      .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data), .rsp_last(lnk.rsp_last), .dev_busy(lnk.dev_busy));

   // Clock at 50 MHz
   always #10 mclk = ~mclk;

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask : check

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Expectation is queued as the read is issued
   task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : reg_read

   // Whole table fetch; the wait covers the fixed sixteen-beat transfer
   task automatic scan(input smd_space_t sp);
      for (int i = 0; i < 16; i++) byte_q.push_back(TBL[i]);
      reg_write(SMD_REG_CTRL, {30'h0, sp, 1'b1});
      repeat (24) @(posedge mclk);
      reg_read(SMD_REG_STATUS, 32'h0000_0006);
   endtask : scan

   // Monitor: a spare byte with an empty queue means a refused start leaked through
   always @(posedge mclk) begin
      if (rd_d) check("reg_rdata", exp_q.pop_front(), reg_rdata);
      if (lnk.rsp_valid) begin
         // The table stays active through every beat but the last one
         check("dev_active", {31'h0, ~lnk.rsp_last}, {31'h0, dev_active});
         if (byte_q.size() == 0) check("spare byte", 32'h0, 32'h1);
         else check("link byte", {24'h0, byte_q.pop_front()}, {23'h0, dev_miss, lnk.rsp_data});
      end
      rd_d <= reg_rd;
   end

   // Watchdog well past the few hundred cycles the tests need
   initial begin
      repeat (4000) @(posedge mclk);
      fail_count++;
      end_sim();
   end

   initial begin
      seed = 32'h3216_a274;
      mclk = 1'b0;
      rstn = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      reg_read(SMD_REG_STATUS, 32'h0);
      reg_read(8'h20, 32'h0);
      $display("test reset done");
      scan(SMD_SPACE_SFDP);
      reg_read(SMD_REG_PROBE0, 32'h0000_0004);
      reg_read(SMD_REG_PROBE1, 32'h0000_0002);
      reg_read(SMD_REG_DESC, 32'h0804_6565);
      $display("test discovery done");
      scan(SMD_SPACE_ALT);
      $display("test alternate done");
      // Second start lands while busy and must be dropped
      for (int i = 0; i < 16; i++) byte_q.push_back(TBL[i]);
      reg_write(SMD_REG_CTRL, 32'h0000_0001);
      reg_write(SMD_REG_CTRL, 32'h0000_0001);
      repeat (30) @(posedge mclk);
      reg_read(SMD_REG_STATUS, 32'h0000_0006);
      $display("test refused start done");
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         reg_write(8'h40 | (r[7:0] & 8'h3c), $random(seed));
         reg_read(8'h40 | (r[7:0] & 8'h3c), 32'h0);
         scan(smd_space_t'(r[8]));
      end
      $display("test random done");
      end_sim();
   end
endmodule : sector_map_detect_descriptor_rom_tb_top
`default_nettype wire
